// ===== rtl/supply_protection_sequencer.sv
// Protection and start-up sequencer driving the power switch gate.
// How it works
// RL1 - Gate high while switch should conduct.
// RL2 - Gate low while switch should not conduct.
// RL3 - Start only after supply reaches turn-on.
// RL4 - Stop all operation at 6.5 V turn-off.
// RL5 - Undervoltage lockout forces gate low.
// RL6 - Undervoltage lockout clears latched stop.
// RL7 - Latch after overvoltage held over 72 us.
// RL8 - Latched: start-up source on 8 V, off 9 V.
// RL9 - Overload below 10 V stops switching at once.
// RL10 - Short stop restarts after 1400 ms, repeating.
// RL11 - No 10 V drop within 70 ms: overload path.
// RL12 - Overload held over 860 ms stops switching.
// RL13 - Start-up source off once operating.
// RL14 - Gate held low in latched or restart stop.
// RL15 - Comparators synchronized, delays counted on clock.
module supply_protection_sequencer #(
  parameter int unsigned OVERVOLTAGE_DELAY = supply_protection_pkg::OVERVOLTAGE_DELAY_CYCLES,
  parameter int unsigned SHORT_WINDOW = supply_protection_pkg::SHORT_WINDOW_CYCLES,
  parameter int unsigned OVERLOAD     = supply_protection_pkg::OVERLOAD_CYCLES,
  parameter int unsigned RESTART      = supply_protection_pkg::RESTART_CYCLES
) (
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire supply_protection_pkg::sense_t sense,
  input  wire logic                          pwm_request,
  output logic                               gate_drive,
  output logic                               startup_source_on,
  output supply_protection_pkg::status_t     status
);

  localparam int W = supply_protection_pkg::CNT_W;

  // Counts saturate, so a condition that never clears cannot wrap round and trip late.
  function automatic logic [W-1:0] bump(input logic [W-1:0] c);
    bump = (c == {W{1'b1}}) ? c : c + 32'h0000_0001;
  endfunction

  // One threshold test shared by every delay, so all end points compare the same way.
  function automatic logic reached(input logic [W-1:0] c, input logic [W-1:0] limit);
    reached = (c >= limit);
  endfunction

  // Synchroniser stages.
  supply_protection_pkg::sense_t  sense_meta;
  supply_protection_pkg::sense_t  s;

  // Mode and output next values.
  supply_protection_pkg::mode_t   mode;
  supply_protection_pkg::mode_t   next_mode;
  supply_protection_pkg::status_t next_status;
  logic                           next_gate;
  logic                           next_startup;

  // Delay counters and their next values.
  logic [W-1:0]                   overvoltage_cnt;
  logic [W-1:0]                   ol_cnt;
  logic [W-1:0]                   restart_cnt;
  logic [W-1:0]                   next_overvoltage_cnt;
  logic [W-1:0]                   next_ol_cnt;
  logic [W-1:0]                   next_restart_cnt;

  // Named comparator levels.
  logic                           turn_on_level;
  logic                           turn_off_level;
  logic                           overvoltage_level;
  logic                           hold_low_level;
  logic                           hold_high_level;
  logic                           short_level;
  logic                           overload_level;

  // Mode decode.
  logic                           running;
  logic                           in_restart;
  logic                           to_lockout;
  logic                           to_run;
  logic                           to_latched;
  logic                           to_restart;

  // Trip conditions.
  logic                           lockout_now;
  logic                           start_now;
  logic                           overvoltage_long;
  logic                           in_short_window;
  logic                           overload_long;
  logic                           restart_done;
  logic                           overvoltage_trip;
  logic                           short_trip;
  logic                           overload_trip;
  logic                           short_seen;
  logic                           overload_seen;

  // Every comparator crosses into the clock domain through two stages.
  always_ff @(posedge clk or posedge reset) begin // see RL15
    if (reset) begin
      sense_meta <= supply_protection_pkg::SENSE_RESET;
    end else begin
      sense_meta <= sense;
    end
  end

  // Only this second stage is read; the first may still be settling.
  always_ff @(posedge clk or posedge reset) begin // see RL15
    if (reset) begin
      s <= supply_protection_pkg::SENSE_RESET;
    end else begin
      s <= sense_meta;
    end
  end

  // Synchronised comparator levels, named for what the logic below asks of them.
  assign turn_on_level     = s.above_turn_on;
  assign turn_off_level    = s.below_turn_off;
  assign overvoltage_level = s.above_overvoltage;
  assign hold_low_level    = s.below_latch_low;
  assign hold_high_level   = s.above_latch_high;
  assign short_level       = s.below_short;
  assign overload_level    = s.cs_overload;

  // Present mode.
  assign running    = (mode == supply_protection_pkg::st_run);
  assign in_restart = (mode == supply_protection_pkg::st_restart);

  // Mode loaded at the next edge; outputs register from it so they move with the mode.
  assign to_lockout = (next_mode == supply_protection_pkg::st_lockout);
  assign to_run     = (next_mode == supply_protection_pkg::st_run);
  assign to_latched = (next_mode == supply_protection_pkg::st_latched);
  assign to_restart = (next_mode == supply_protection_pkg::st_restart);

  assign lockout_now = turn_off_level; // see RL4
  assign start_now   = turn_on_level; // see RL3

  // Delay end points.
  assign overvoltage_long = reached(overvoltage_cnt, W'(OVERVOLTAGE_DELAY));
  assign in_short_window  = !reached(ol_cnt, W'(SHORT_WINDOW));
  assign overload_long    = reached(ol_cnt, W'(OVERLOAD));
  assign restart_done     = reached(restart_cnt, W'(RESTART));

  assign overvoltage_trip = overvoltage_level && overvoltage_long; // see RL7
  // The short check only looks inside its window; later the overload timer decides.
  assign short_trip       = running && overload_level && short_level
                            && in_short_window; // see RL9 see RL11
  assign overload_trip    = running && overload_level && overload_long; // see RL12

  always_comb begin
    next_mode = mode;
    case (mode)
      supply_protection_pkg::st_lockout: begin
        // Nothing but the turn-on level acts here.
        if (start_now) begin
          next_mode = supply_protection_pkg::st_run; // see RL3
        end
      end

      supply_protection_pkg::st_run: begin
        if (overvoltage_trip) begin
          next_mode = supply_protection_pkg::st_latched;
        end else if (short_trip || overload_trip) begin
          next_mode = supply_protection_pkg::st_restart;
        end
      end

      supply_protection_pkg::st_latched: begin
        // Only lockout leaves this state; the start-up source holds the supply meanwhile.
        next_mode = supply_protection_pkg::st_latched; // see RL14
      end

      supply_protection_pkg::st_restart: begin
        // A short that persists trips again after the restart, so the cycle repeats.
        if (restart_done) begin
          next_mode = supply_protection_pkg::st_run; // see RL10
        end
      end

      default: begin
        next_mode = supply_protection_pkg::st_lockout;
      end
    endcase
    // Lockout outranks everything and wipes the latch with it.
    if (lockout_now) begin
      next_mode = supply_protection_pkg::st_lockout; // see RL5 see RL6
    end
  end

  // Gate follows the regulator only while running; any stop pulls it low on the same edge.
  assign next_gate = to_run
                     && pwm_request; // see RL1 see RL2 see RL14

  // Between the two hold levels the source keeps its last state; that gap is the hysteresis.
  always_comb begin
    next_startup = startup_source_on;
    case (next_mode)
      supply_protection_pkg::st_lockout: begin
        next_startup = 1'b1;
      end

      supply_protection_pkg::st_run: begin
        next_startup = 1'b0; // see RL13
      end

      supply_protection_pkg::st_latched: begin
        if (hold_low_level) begin
          next_startup = 1'b1; // see RL8
        end else if (hold_high_level) begin
          next_startup = 1'b0; // see RL8
        end
      end

      supply_protection_pkg::st_restart: begin
        // The supply is left to decay; if it collapses, lockout recharges it.
        next_startup = 1'b0;
      end

      default: begin
        next_startup = 1'b1;
      end
    endcase
  end

  // Trip flags stay set until lockout, so the cause of a stop remains visible.
  assign short_seen    = status.short_trip || short_trip;
  assign overload_seen = status.overload_trip || (overload_trip && !short_trip);

  assign next_status = '{
    operating:     to_run,
    latched:       to_latched,
    restart_wait:  to_restart,
    short_trip:    short_seen && !to_lockout,
    overload_trip: overload_seen && !to_lockout
  };

  // Any dropout of the condition restarts its count, so brief noise never trips.
  assign next_overvoltage_cnt = (running && overvoltage_level) ? bump(overvoltage_cnt)
                                : supply_protection_pkg::CNT_RESET; // see RL7
  assign next_ol_cnt          = (running && overload_level) ? bump(ol_cnt)
                                : supply_protection_pkg::CNT_RESET; // see RL11 see RL12
  assign next_restart_cnt     = (in_restart && !restart_done) ? bump(restart_cnt)
                                : supply_protection_pkg::CNT_RESET; // see RL10

  // Reset parks the block in lockout, the same as a collapsed supply.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode <= supply_protection_pkg::st_lockout;
    end else begin
      mode <= next_mode;
    end
  end

  // Gate and start-up source come from flops, so decoding never glitches the pins.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gate_drive <= 1'b0;
    end else begin
      gate_drive <= next_gate;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      startup_source_on <= 1'b1;
    end else begin
      startup_source_on <= next_startup;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status <= supply_protection_pkg::STATUS_RESET;
    end else begin
      status <= next_status;
    end
  end

  // Every protection delay is counted on this clock.
  always_ff @(posedge clk or posedge reset) begin // see RL15
    if (reset) begin
      overvoltage_cnt <= supply_protection_pkg::CNT_RESET;
    end else begin
      overvoltage_cnt <= next_overvoltage_cnt;
    end
  end

  always_ff @(posedge clk or posedge reset) begin // see RL15
    if (reset) begin
      ol_cnt <= supply_protection_pkg::CNT_RESET;
    end else begin
      ol_cnt <= next_ol_cnt;
    end
  end

  always_ff @(posedge clk or posedge reset) begin // see RL15
    if (reset) begin
      restart_cnt <= supply_protection_pkg::CNT_RESET;
    end else begin
      restart_cnt <= next_restart_cnt;
    end
  end

endmodule

// ===== common/supply_protection_pkg.sv
// Shared constants and carrier types for the supply protection sequencer.
package supply_protection_pkg;

  localparam int unsigned CLK_MHZ = 200;

  localparam int unsigned OVERVOLTAGE_DELAY_US = 72;
  localparam int unsigned SHORT_WINDOW_MS = 70;
  localparam int unsigned OVERLOAD_MS    = 860;
  localparam int unsigned RESTART_MS     = 1400;

  localparam int unsigned OVERVOLTAGE_DELAY_CYCLES = OVERVOLTAGE_DELAY_US * CLK_MHZ;
  localparam int unsigned SHORT_WINDOW_CYCLES = SHORT_WINDOW_MS * 1000 * CLK_MHZ;
  localparam int unsigned OVERLOAD_CYCLES     = OVERLOAD_MS * 1000 * CLK_MHZ;
  localparam int unsigned RESTART_CYCLES      = RESTART_MS * 1000 * CLK_MHZ;

  localparam int CNT_W = 32;

  typedef enum {
    st_lockout,
    st_run,
    st_latched,
    st_restart
  } mode_t;

  typedef struct packed {
    logic above_turn_on;
    logic below_turn_off;
    logic above_overvoltage;
    logic below_latch_low;
    logic above_latch_high;
    logic below_short;
    logic cs_overload;
  } sense_t;

  typedef struct packed {
    logic operating;
    logic latched;
    logic restart_wait;
    logic short_trip;
    logic overload_trip;
  } status_t;

  // Comparators reset as if the supply sat below the turn-off level.
  localparam sense_t SENSE_RESET = 7'h20;
  localparam status_t STATUS_RESET = 5'h00;
  localparam logic [CNT_W-1:0] CNT_RESET = 32'h0000_0000;

endpackage

// ===== verification/supply_model.sv
// Comparator model of the supply and sense pins, in tenths of a volt.
module supply_model #(
  parameter int ON = 150
) (
  input  int                            v,
  input  wire logic                     cs,
  output supply_protection_pkg::sense_t s
);
  timeunit 1ns;
  timeprecision 1ps;
  // The turn-on level is not fixed here, so it is a parameter.
  assign s = '{v >= ON, v <= 65, v > 255, v <= 80, v >= 90, v < 100, cs};
endmodule

// ===== verification/supply_protection_asserts.sv
// Port checks for the supply protection sequencer.
module supply_protection_asserts #(
  parameter int unsigned OVERVOLTAGE_DELAY = 20,
  parameter int unsigned RESTART   = 100
) (
  input wire logic                           clk,
  input wire logic                           reset,
  input wire supply_protection_pkg::sense_t  sense,
  input wire logic                           pwm_request,
  input wire logic                           gate_drive,
  input wire logic                           startup_source_on,
  input wire supply_protection_pkg::status_t status
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RLO = RESTART - 2;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence restart_seq;
    $rose(status.restart_wait);
  endsequence
  a_gate_needs_run: assert property (gate_drive |-> status.operating)
    else $error("gate high outside run");
  a_gate_follows_req: assert property (status.operating && $past(status.operating)
    |-> gate_drive == $past(pwm_request)) else $error("gate not following request");
  a_lockout_clears: assert property (sense.below_turn_off[*3]
    |=> !gate_drive && startup_source_on && !status.latched) else $error("lockout failed");
  a_latch_holds: assert property (status.latched && !$past(sense.below_turn_off, 2)
    && !$past(sense.below_turn_off) && !sense.below_turn_off
    |=> status.latched) else $error("latch lost");
  a_latch_quiet: assert property (status.latched |-> !gate_drive && !status.operating)
    else $error("switching while latched");
  a_overvoltage_filter: assert property ($rose(status.latched)
    |-> $past(sense.above_overvoltage, 4) && $past(sense.above_overvoltage, OVERVOLTAGE_DELAY))
    else $error("latched without long overvoltage");
  a_source_off_run: assert property (status.operating |-> !startup_source_on)
    else $error("start-up source on in run");
  a_stop_quiet: assert property (status.restart_wait |-> !gate_drive && !status.operating)
    else $error("switching in restart wait");
  a_restart_time: assert property (restart_seq |-> ##RLO !status.operating
    ##[1:6] status.operating) else $error("restart delay wrong");
endmodule
bind supply_protection_sequencer supply_protection_asserts #(.OVERVOLTAGE_DELAY(OVERVOLTAGE_DELAY),
  .RESTART(RESTART)) u_supply_protection_asserts (.clk(clk), .reset(reset), .sense(sense),
  .pwm_request(pwm_request), .gate_drive(gate_drive),
  .startup_source_on(startup_source_on), .status(status));

// ===== verification/supply_protection_sequencer_tb.sv
// Self-checking bench for the supply protection sequencer.
module supply_protection_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                           clk = 0;
  logic                           reset = 1;
  logic                           pwm = 0;
  logic                           cs = 0;
  int                             v = 0;
  int                             mismatches = 0;
  int                             num_checks = 0;
  supply_protection_pkg::sense_t  sense;
  supply_protection_pkg::status_t st;
  logic                           gate;
  logic                           su;
  supply_model u_supply_model (.v(v), .cs(cs), .s(sense));
  // Short counts keep the run brief; the checker receives the same values.
  supply_protection_sequencer #(.OVERVOLTAGE_DELAY(20), .SHORT_WINDOW(50), .OVERLOAD(200),
    .RESTART(100)) u_supply_protection_sequencer (.clk(clk), .reset(reset), .sense(sense),
    .pwm_request(pwm), .gate_drive(gate), .startup_source_on(su), .status(st));
  initial forever #2.5 clk = ~clk;
  task chk(input logic g, input logic e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t: got %b expected %b", $time, g, e);
    end
  endtask
  task w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task power_up;
    v = 100; w(6); chk(st.operating, 0);
    v = 160; pwm = 1; w(4); chk(st.operating, 1);
    chk(su, 0);
    chk(gate, 1);
    pwm = 0; w(2); chk(gate, 0);
    pwm = 1; w(2);
  endtask
  task short_stop;
    v = 90; cs = 1; w(4); chk(gate, 0);
    chk(st.short_trip, 1);
    cs = 0; v = 160; w(90); chk(st.restart_wait, 1);
    w(15); chk(st.operating, 1);
  endtask
  task overload;
    cs = 1; w(60); v = 90; w(10); chk(st.restart_wait, 0);
    w(140); chk(st.overload_trip, 1);
    chk(gate, 0);
    cs = 0; v = 160; w(110);
  endtask
  task latch_stop;
    v = 260; w(12); v = 160; w(30); chk(st.latched, 0);
    v = 260; w(30); chk(st.latched, 1);
    v = 85; w(5); chk(su, 0);
    v = 75; w(5); chk(su, 1);
    v = 95; w(5); chk(su, 0);
    chk(st.latched, 1);
    v = 60; w(5); chk(st.latched, 0);
    chk(gate, 0);
    chk(st.short_trip, 0);
    chk(st.overload_trip, 0);
    chk(su, 1);
  endtask
  initial begin
    w(10);
    reset = 0;
    power_up();
    short_stop();
    overload();
    latch_stop();
    end_of_test();
  end
  initial begin
    #20000;
    mismatches++;
    end_of_test();
  end
endmodule
